//--- design/vcrc_pkg.sv
package vcrc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PORT_VC = 12'h14c;
  localparam logic [ADDR_W-1:0] OFS_VC0_CAP = 12'h150;
  localparam logic [ADDR_W-1:0] OFS_VC0_CTL = 12'h154;

  // ----------------------------------------------------------------
  // Port VC word fields
  // ----------------------------------------------------------------
  localparam int unsigned PVC_LOAD_BIT = 0;
  localparam int unsigned PVC_STAT_BIT = 16;

  // ----------------------------------------------------------------
  // VC0 capability word
  // ----------------------------------------------------------------
  localparam logic [7:0] CAP_PORT_ARB   = 8'h09;
  localparam logic [6:0] CAP_MAX_SLOTS  = 7'h7f;
  localparam logic [7:0] CAP_TABLE_OFS  = 8'h04;
  localparam logic [DATA_W-1:0] CAP_WORD =
    {CAP_TABLE_OFS, 1'b0, CAP_MAX_SLOTS, 1'b0, 1'b0, 6'h00, CAP_PORT_ARB};

  // ----------------------------------------------------------------
  // VC0 control word fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTL_MAP_LSB  = 0;
  localparam int unsigned CTL_LOAD_BIT = 16;
  localparam int unsigned CTL_SEL_LSB  = 17;
  localparam int unsigned CTL_ID_LSB   = 24;
  localparam int unsigned CTL_EN_BIT   = 31;
  localparam logic [7:0] RST_TC_MAP    = 8'hff;
  localparam logic [2:0] RST_ARB_SEL   = 3'h0;
  localparam logic       RST_VC_EN     = 1'b1;
  localparam logic [2:0] VC0_ID        = 3'h0;

  // ----------------------------------------------------------------
  // Port arbitration schemes accepted on this channel
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_DEFAULT = 3'h0;
  localparam logic [2:0] SEL_WRR128  = 3'h3;

  // ----------------------------------------------------------------
  // Bus handshake states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VCRC_IDLE = 2'b01,
    VCRC_ACK  = 2'b10
  } vcrc_bus_e;

endpackage

//--- design/vcrc_regs.sv
`timescale 1ns/1ps
module vcrc_regs
  import vcrc_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Avalon-MM slave
  input  wire logic [vcrc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [vcrc_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [vcrc_pkg::BE_W-1:0]   avs_byteenable,
  output logic      [vcrc_pkg::DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  // Arbitration hardware side
  input  wire logic                        vc_arb_table_wr,
  input  wire logic                        vc_arb_load_done,
  output logic                             vc_arb_load,
  output logic                             port_arb_load,
  // Management or EEPROM preset of the class map
  input  wire logic                        tc_map_preset_valid,
  input  wire logic [7:0]                  tc_map_preset,
  // Channel settings
  output logic      [7:0]                  tc_vc_map,
  output logic      [2:0]                  port_arb_sel,
  output logic                             vc_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  vcrc_bus_e          bus_ff;
  vcrc_bus_e          nxt_bus;
  logic [DATA_W-1:0]  rdata_ff;
  logic [DATA_W-1:0]  nxt_rdata;
  logic               wait_ff;
  logic               vc_stat_ff;
  logic               vc_load_ff;
  logic               port_load_ff;
  logic [7:0]         map_ff;
  logic [7:0]         nxt_map;
  logic [2:0]         sel_ff;
  logic               en_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic          req;
  wire logic          commit;
  wire logic          hit_pvc;
  wire logic          hit_cap;
  wire logic          hit_ctl;
  wire logic          wr_ctl;
  wire logic          wr_pvc;
  wire logic [2:0]    wsel;
  wire logic [2:0]    sel_ok;
  wire logic [DATA_W-1:0] pvc_word;
  wire logic [DATA_W-1:0] ctl_word;

  assign req     = avs_read | avs_write;
  // The write lands on the edge where the master sees waitrequest low.
  assign commit  = avs_write & (bus_ff == VCRC_ACK);
  assign hit_pvc = (avs_address == OFS_PORT_VC);
  assign hit_cap = (avs_address == OFS_VC0_CAP);
  assign hit_ctl = (avs_address == OFS_VC0_CTL);
  assign wr_ctl  = commit & hit_ctl;
  assign wr_pvc  = commit & hit_pvc;
  assign wsel    = avs_writedata[CTL_SEL_LSB +: 3];
  // Unsupported schemes fall back to the default one.
  assign sel_ok  = ((wsel == SEL_DEFAULT) || (wsel == SEL_WRR128)) ?
                   wsel : SEL_DEFAULT;

  // Load bits read zero; every reserved bit reads zero.
  assign pvc_word = {{(DATA_W-PVC_STAT_BIT-1){1'b0}}, vc_stat_ff,
                     {PVC_STAT_BIT{1'b0}}};
  assign ctl_word = {en_ff, 4'h0, VC0_ID, 4'h0, sel_ff, 1'b0,
                     8'h00, map_ff};

  // ----------------------------------------------------------------
  // Read mux and handshake
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (hit_pvc) begin
      nxt_rdata = pvc_word;
    end else if (hit_cap) begin
      nxt_rdata = CAP_WORD;
    end else if (hit_ctl) begin
      nxt_rdata = ctl_word;
    end
  end

  // One wait cycle per access, then a single acknowledge cycle; back
  // to back requests are accepted because ACK always returns to IDLE.
  always_comb begin
    nxt_bus = VCRC_IDLE;
    unique case (bus_ff)
      VCRC_IDLE: begin
        if (req) begin
          nxt_bus = VCRC_ACK;
        end
      end
      VCRC_ACK: begin
        nxt_bus = VCRC_IDLE;
      end
      default: begin
        nxt_bus = VCRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_ff   <= VCRC_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      bus_ff   <= nxt_bus;
      wait_ff  <= (nxt_bus != VCRC_ACK);
      rdata_ff <= (nxt_bus == VCRC_ACK) ? nxt_rdata : '0;
    end
  end

  // ----------------------------------------------------------------
  // Vc_arb_table_status and load pulses
  // ----------------------------------------------------------------
  wire logic vc_load_req;
  wire logic port_load_req;

  assign vc_load_req   = wr_pvc & avs_byteenable[0] &
                         avs_writedata[PVC_LOAD_BIT];
  assign port_load_req = wr_ctl & avs_byteenable[2] &
                         avs_writedata[CTL_LOAD_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vc_stat_ff   <= 1'b0;
      vc_load_ff   <= 1'b0;
      port_load_ff <= 1'b0;
    end else begin
      // A table write in the same cycle as load-done keeps the flag set.
      if (vc_arb_table_wr) begin
        vc_stat_ff <= 1'b1;
      end else if (vc_arb_load_done) begin
        vc_stat_ff <= 1'b0;
      end
      vc_load_ff   <= vc_load_req;
      port_load_ff <= port_load_req;
    end
  end

  // ----------------------------------------------------------------
  // VC0 control fields
  // ----------------------------------------------------------------
  // Per-bit merge so a partial byte enable only touches its own lane.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_map
      always_comb begin
        nxt_map[gi] = map_ff[gi];
        if (tc_map_preset_valid) begin
          nxt_map[gi] = tc_map_preset[gi];
        end else if (wr_ctl && avs_byteenable[0]) begin
          nxt_map[gi] = avs_writedata[CTL_MAP_LSB + gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      map_ff <= RST_TC_MAP;
      sel_ff <= RST_ARB_SEL;
      en_ff  <= RST_VC_EN;
    end else begin
      map_ff <= nxt_map;
      if (wr_ctl && avs_byteenable[2]) begin
        sel_ff <= sel_ok;
      end
      if (wr_ctl && avs_byteenable[3]) begin
        en_ff <= avs_writedata[CTL_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign vc_arb_load     = vc_load_ff;
  assign port_arb_load   = port_load_ff;
  assign tc_vc_map       = map_ff;
  assign port_arb_sel    = sel_ff;
  assign vc_enable       = en_ff;

endmodule

//--- test/vcrc_regs_properties.sv
`timescale 1ns/1ps
module vcrc_regs_props
  import vcrc_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [BE_W-1:0]   avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Arbitration side and settings
  input wire logic              vc_arb_table_wr,
  input wire logic              vc_arb_load_done,
  input wire logic              vc_arb_load,
  input wire logic              port_arb_load,
  input wire logic              tc_map_preset_valid,
  input wire logic [7:0]        tc_map_preset,
  input wire logic [7:0]        tc_vc_map,
  input wire logic [2:0]        port_arb_sel,
  input wire logic              vc_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rack = avs_read && !avs_waitrequest;
  wire wack = avs_write && !avs_waitrequest;
  wire wctl = wack && avs_address == OFS_VC0_CTL;
  sequence pvc_load_s;
    wack && avs_address == OFS_PORT_VC && avs_byteenable[0] && avs_writedata[0];
  endsequence
  sequence ctl_load_s;
    wctl && avs_byteenable[2] && avs_writedata[16];
  endsequence
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held longer than one cycle");
  AST_IDLE_ZERO: assert property (avs_waitrequest |-> avs_readdata == '0)
    else $error("read data not zero outside ack");
  AST_STAT_SET: assert property (rack && avs_address == OFS_PORT_VC
    && $past(vc_arb_table_wr, 2) |-> avs_readdata[16]) else $error("status flag not set");
  AST_STAT_CLR: assert property (rack && avs_address == OFS_PORT_VC &&
    $past(vc_arb_load_done, 2) && !$past(vc_arb_table_wr, 2) |-> !avs_readdata[16])
    else $error("status flag not cleared");
  AST_PVC_RD: assert property (rack && avs_address == OFS_PORT_VC |->
    {avs_readdata[31:17], avs_readdata[15:0]} == '0) else $error("port word bits wrong");
  AST_CAP: assert property (rack && avs_address == OFS_VC0_CAP |->
    avs_readdata == 32'h047f0009) else $error("capability word wrong");
  AST_CTL_RD: assert property (rack && avs_address == OFS_VC0_CTL |-> avs_readdata ==
    {$past(vc_enable), 11'h0, $past(port_arb_sel), 9'h0, $past(tc_vc_map)})
    else $error("control word readback wrong");
  AST_VLOAD: assert property (pvc_load_s |=> vc_arb_load ##1 !vc_arb_load)
    else $error("table load pulse wrong");
  AST_PLOAD: assert property (ctl_load_s |=> port_arb_load ##1 !port_arb_load)
    else $error("port load pulse wrong");
  AST_SEL: assert property (wctl && avs_byteenable[2] |=> port_arb_sel ==
    (($past(avs_writedata[19:17]) == SEL_WRR128) ? SEL_WRR128 : SEL_DEFAULT))
    else $error("select not stored as expected");
  AST_MAP: assert property (wctl && avs_byteenable[0] && !tc_map_preset_valid |=>
    tc_vc_map == $past(avs_writedata[7:0])) else $error("class map not written");
  AST_PRESET: assert property (tc_map_preset_valid |=>
    tc_vc_map == $past(tc_map_preset)) else $error("preset not loaded");
  AST_EN: assert property (wctl && avs_byteenable[3] |=>
    vc_enable == $past(avs_writedata[31])) else $error("enable not written");
endmodule

bind vcrc_regs vcrc_regs_props vcrc_regs_props_inst (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .vc_arb_table_wr(vc_arb_table_wr), .vc_arb_load_done(vc_arb_load_done),
  .vc_arb_load(vc_arb_load), .port_arb_load(port_arb_load),
  .tc_map_preset_valid(tc_map_preset_valid), .tc_map_preset(tc_map_preset),
  .tc_vc_map(tc_vc_map), .port_arb_sel(port_arb_sel), .vc_enable(vc_enable));

//--- test/vcrc_regs_tb.sv
`timescale 1ns/1ps
module vcrc_regs_tb;
  import vcrc_pkg::*;
  logic              clk = 1'b0, resetn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0, avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0, avs_readdata;
  logic [BE_W-1:0]   avs_byteenable = '0;
  logic              avs_waitrequest, vc_arb_load, port_arb_load, vc_enable;
  logic              vc_arb_table_wr = 1'b0, vc_arb_load_done = 1'b0, tc_map_preset_valid = 1'b0;
  logic [7:0]        tc_map_preset = '0, tc_vc_map, m;
  logic [2:0]        port_arb_sel;
  logic [31:0]       exp_q[$];
  integer            seed = 32'h9fe0ed4b;
  int                fails = 0, num_checks = 0;

  vcrc_regs vcrc_regs_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vc_arb_table_wr(vc_arb_table_wr),
    .vc_arb_load_done(vc_arb_load_done), .vc_arb_load(vc_arb_load),
    .port_arb_load(port_arb_load), .tc_map_preset_valid(tc_map_preset_valid),
    .tc_map_preset(tc_map_preset), .tc_vc_map(tc_vc_map), .port_arb_sel(port_arb_sel),
    .vc_enable(vc_enable));

  initial forever #4 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Read data stand only in the ack cycle; the rising edge that ends it is where they are taken.
  always @(posedge clk) begin
    if (resetn && avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk("read without note", 32'h0, 32'h1);
      else chk("avs_readdata", exp_q.pop_front(), avs_readdata);
    end
  end

  // The request is left up on return so a following call runs back to back.
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, input logic [31:0] e);
    int n;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (!w) exp_q.push_back(e);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      chk("waitrequest timeout", 32'h0, 32'h1);
      final_report();
    end
  endtask

  task automatic idle();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("tc_vc_map", {24'h0, RST_TC_MAP}, {24'h0, tc_vc_map});
    acc(1'b0, OFS_PORT_VC, 32'h0, 4'hf, 32'h0);
    acc(1'b0, OFS_VC0_CAP, 32'h0, 4'hf, 32'h047f0009);
    acc(1'b0, OFS_VC0_CTL, 32'h0, 4'hf, 32'h800000ff);
    acc(1'b1, OFS_VC0_CAP, 32'hffffffff, 4'hf, 32'h0);
    acc(1'b0, OFS_VC0_CAP, 32'h0, 4'hf, 32'h047f0009);
    acc(1'b0, 12'h158, 32'h0, 4'hf, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = 8'($random(seed));
      acc(1'b1, OFS_VC0_CTL, {i[0], 4'hf, 3'h7, 4'hf, i[2:0], 1'b0, 8'hff, m}, 4'hf, 0);
      acc(1'b0, OFS_VC0_CTL, 0, 4'hf, {i[0], 11'h0, (i == 3) ? 3'h3 : 3'h0, 9'h0, m});
    end
    acc(1'b1, OFS_VC0_CTL, 32'h00010000, 4'h4, 32'h0);
    idle();
    chk("port_arb_load", 32'h1, {31'h0, port_arb_load});
    chk("port_arb_sel", {29'h0, SEL_DEFAULT}, {29'h0, port_arb_sel});
    chk("vc_enable", 32'h1, {31'h0, vc_enable});
    acc(1'b1, OFS_VC0_CTL, 32'h0, 4'h1, 32'h0);
    acc(1'b0, OFS_VC0_CTL, 32'h0, 4'hf, 32'h80000000);
    idle();
    vc_arb_table_wr <= 1'b1;
    @(posedge clk);
    vc_arb_table_wr <= 1'b0;
    acc(1'b0, OFS_PORT_VC, 32'h0, 4'hf, 32'h00010000);
    acc(1'b1, OFS_PORT_VC, 32'hffffffff, 4'hf, 32'h0);
    idle();
    chk("vc_arb_load", 32'h1, {31'h0, vc_arb_load});
    acc(1'b0, OFS_PORT_VC, 32'h0, 4'hf, 32'h00010000);
    idle();
    vc_arb_load_done <= 1'b1;
    @(posedge clk);
    vc_arb_load_done <= 1'b0;
    acc(1'b0, OFS_PORT_VC, 32'h0, 4'hf, 32'h0);
    idle();
    tc_map_preset <= 8'h5a;
    tc_map_preset_valid <= 1'b1;
    @(posedge clk);
    tc_map_preset_valid <= 1'b0;
    acc(1'b0, OFS_VC0_CTL, 32'h0, 4'hf, 32'h8000005a);
    idle();
    final_report();
  end
endmodule
